// ### src/rsspi_pkg.sv
// package: constants for the rate sensor serial register port
package rsspi_pkg;
	localparam logic [6:0] RSSPI_ADDR_FLASH_CNT = 7'h00;
	localparam logic [6:0] RSSPI_ADDR_TEMP = 7'h02;
	localparam logic [6:0] RSSPI_ADDR_RATE_LOW = 7'h04;
	localparam logic [6:0] RSSPI_ADDR_RATE_HIGH = 7'h06;
	localparam logic [6:0] RSSPI_ADDR_CFG_FIRST = 7'h08;
	localparam logic [6:0] RSSPI_ADDR_CFG_LAST = 7'h25;
	localparam logic [6:0] RSSPI_ADDR_SAMPLE_PERIOD_SETTING = 7'h1E;
	localparam logic [6:0] RSSPI_ADDR_DEC = 7'h22;
	localparam logic [6:0] RSSPI_ADDR_GLOBAL_COMMAND = 7'h28;
	localparam int RSSPI_BACKUP_BIT = 3;
	localparam int RSSPI_FRAME_BITS = 16;
	localparam int RSSPI_RW_BIT = 15;
	localparam logic [15:0] RSSPI_SAMPLE_PERIOD_SETTING_RST = 16'h000F;
	localparam logic [15:0] RSSPI_MSC_RST = 16'h0006;
	localparam logic [6:0] RSSPI_ADDR_MSC = 7'h1C;
	localparam int RSSPI_NUM_CFG_BYTES = 30;
	// internal sample tick: 32768 Hz base at 20 MHz clock
	localparam int RSSPI_MCLK_HZ = 20000000;
	localparam int RSSPI_BASE_HZ = 32768;
	localparam int RSSPI_BASE_DIV = RSSPI_MCLK_HZ / RSSPI_BASE_HZ;
	localparam int RSSPI_DR_PULSE_CYC = 4;
	// startup init time (ms) before sampling begins
	localparam int RSSPI_INIT_MS = 245;
	localparam int RSSPI_INIT_CYC = RSSPI_INIT_MS * (RSSPI_MCLK_HZ / 1000);
endpackage

// ### src/rsspi_sync3.sv
// module: three-stage synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module rsspi_sync3 #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic din,
	output logic dout
);
	typedef struct packed {
		logic [2:0] sh;
		logic out;
	} rsspi_sync_type;
	rsspi_sync_type st_q, st_d;
	always_comb begin
		st_d = st_q;
		st_d.sh = {st_q.sh[1:0], din};
		if (st_q.sh[1] == st_q.sh[2]) begin
			st_d.out = st_q.sh[2];
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= {{3{RST_VAL}}, RST_VAL};
		end else if (ce) begin
			st_q <= st_d;
		end
	end
	assign dout = st_q.out;
endmodule
`default_nettype wire

// ### src/rsspi_link.sv
// module: serial shift engine on the host serial clock
`timescale 1ns/1ns
`default_nettype none
module rsspi_link
	import rsspi_pkg::*;
(
	input wire logic sclk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic [15:0] tx_word,
	input wire logic tx_en,
	output logic [15:0] rx_word,
	output logic rx_tog,
	output logic miso,
	output logic miso_oe
);
	typedef struct packed {
		logic [14:0] rx_sh;
		logic [3:0] cnt;
	} rsspi_rx_type;
	typedef struct packed {
		logic [15:0] rx_word;
		logic rx_tog;
	} rsspi_word_type;
	typedef struct packed {
		logic [15:0] tx_sh;
	} rsspi_tx_type;
	rsspi_rx_type r_q, r_d;
	rsspi_word_type w_q, w_d;
	rsspi_tx_type t_q, t_d;
	// capture on rising edges
	always_comb begin
		r_d = r_q;
		w_d = w_q;
		r_d.rx_sh = {r_q.rx_sh[13:0], mosi};
		r_d.cnt = r_q.cnt + 4'h1;
		if (r_q.cnt == 4'hF) begin
			w_d.rx_word = {r_q.rx_sh, mosi};
			w_d.rx_tog = ~w_q.rx_tog;
		end
	end
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end
	// word and toggle survive deselect
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			w_q <= '0;
		end else begin
			w_q <= w_d;
		end
	end
	// launch on falling edges, msb first
	always_comb begin
		t_d = t_q;
		if (r_q.cnt == 4'h0) begin
			t_d.tx_sh = tx_en ? tx_word : 16'h0000;
		end else begin
			t_d.tx_sh = {t_q.tx_sh[14:0], 1'b0};
		end
	end
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			t_q <= '0;
		end else begin
			t_q <= t_d;
		end
	end
	assign rx_word = w_q.rx_word;
	assign rx_tog = w_q.rx_tog;
	assign miso = t_q.tx_sh[15];
	assign miso_oe = ~cs_n;
endmodule
`default_nettype wire

// ### src/rsspi_top.sv
// module: rate sensor serial slave port and register bank
`timescale 1ns/1ns
`default_nettype none
module rsspi_top
	import rsspi_pkg::*;
#(
	parameter int INIT_CYC = RSSPI_INIT_CYC,
	parameter int NBYTES = RSSPI_NUM_CFG_BYTES
) (
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic CE,
	input wire logic SCLK,
	input wire logic CS_N,
	input wire logic MOSI,
	output logic MISO,
	output logic MISO_OE,
	output logic SAMPLE_DONE_PIN,
	input wire logic AUX_IO_OR_EXT_CLOCK_PIN,
	input wire logic [15:0] RATE_SAMPLE,
	input wire logic [15:0] RATE_EXT_SAMPLE,
	input wire logic [15:0] TEMP_SAMPLE,
	output logic [15:0] FLASH_WRITE_COUNT,
	output logic EXT_CLOCK_MODE,
	output logic [4:0] DECIMATION_SETTING
);
	typedef enum logic [2:0] {
		ST_INIT = 3'b001,
		ST_RUN = 3'b010,
		ST_SAVE = 3'b100
	} rsspi_state_type;

	typedef struct packed {
		rsspi_state_type st;
		logic [31:0] init_cnt;
		logic [15:0] base_cnt;
		logic [15:0] per_cnt;
		logic [2:0] dr_cnt;
		logic dr_pin;
		logic ext_prev;
		logic [2:0] tog_sync;
		logic tog_seen;
		logic [15:0] rate_q;
		logic [15:0] rate_ext_q;
		logic [15:0] temp_q;
		logic [15:0] flash_cnt;
		logic [15:0] tx_word;
		logic tx_en;
		logic [4:0] save_idx;
		logic ext_mode;
	} rsspi_core_type;

	rsspi_core_type c_q, c_d;
	logic [7:0] work_q [NBYTES];
	logic [7:0] flash_q [NBYTES];
	logic [15:0] rx_word;
	logic rx_tog;
	logic miso_w;
	logic miso_oe_w;
	logic ext_clk_s;
	logic [15:0] flash_cnt_nv;

	rsspi_link u_link (
		.sclk(SCLK),
		.rst_n(RSTN),
		.cs_n(CS_N),
		.mosi(MOSI),
		.tx_word(c_q.tx_word),
		.tx_en(c_q.tx_en),
		.rx_word(rx_word),
		.rx_tog(rx_tog),
		.miso(miso_w),
		.miso_oe(miso_oe_w)
	);

	rsspi_sync3 #(
		.RST_VAL(1'b0)
	) u_ext_sync (
		.clk(MCLK),
		.rst_n(RSTN),
		.ce(CE),
		.din(AUX_IO_OR_EXT_CLOCK_PIN),
		.dout(ext_clk_s)
	);

	function automatic logic is_cfg(input logic [6:0] a);
		return (a >= RSSPI_ADDR_CFG_FIRST) && (a <= RSSPI_ADDR_CFG_LAST);
	endfunction

	function automatic logic [4:0] cfg_idx(input logic [6:0] a);
		logic [6:0] d;
		d = a - RSSPI_ADDR_CFG_FIRST;
		return d[4:0];
	endfunction

	function automatic logic [15:0] cfg_word(input logic [6:0] a);
		logic [4:0] i;
		i = cfg_idx({a[6:1], 1'b0});
		return {work_q[i + 5'd1], work_q[i]};
	endfunction

	// msb-justified extension, valid width equal to decimation setting
	function automatic logic [15:0] ext_mask(input logic [4:0] n);
		logic [15:0] m;
		m = '0;
		for (int k = 0; k < 16; k++) begin
			if (k < int'(n)) begin
				m[15 - k] = 1'b1;
			end
		end
		return m;
	endfunction

	logic [15:0] sample_period_setting;
	logic [4:0] dec_set;
	logic [6:0] rx_addr;
	logic rx_new;
	assign sample_period_setting = cfg_word(RSSPI_ADDR_SAMPLE_PERIOD_SETTING);
	assign dec_set = work_q[cfg_idx(RSSPI_ADDR_DEC)][4:0];
	assign rx_addr = rx_word[14:8];
	// toggle counts once second and third stage agree; word long stable then
	assign rx_new = (c_q.tog_sync[2] == c_q.tog_sync[1]) && (c_q.tog_sync[2] != c_q.tog_seen);

	logic tick;
	logic wr_cfg;

	always_comb begin
		c_d = c_q;
		tick = 1'b0;
		wr_cfg = 1'b0;
		c_d.tog_sync = {c_q.tog_sync[1:0], rx_tog};
		c_d.ext_prev = ext_clk_s;
		c_d.ext_mode = (sample_period_setting == 16'h0000);
		if (c_q.dr_cnt != 3'd0) begin
			c_d.dr_cnt = c_q.dr_cnt - 3'd1;
		end
		c_d.dr_pin = (c_q.dr_cnt != 3'd0);
		case (c_q.st)
			ST_INIT: begin
				c_d.flash_cnt = flash_cnt_nv;
				// wait out startup, then run with no host command
				if (c_q.init_cnt >= 32'(INIT_CYC - 1)) begin
					c_d.st = ST_RUN;
				end else begin
					c_d.init_cnt = c_q.init_cnt + 32'd1;
				end
			end
			ST_RUN: begin
				if (c_q.ext_mode) begin
					tick = ext_clk_s & ~c_q.ext_prev;
				end else begin
					if (c_q.base_cnt >= 16'(RSSPI_BASE_DIV - 1)) begin
						c_d.base_cnt = '0;
						if (c_q.per_cnt >= sample_period_setting) begin
							c_d.per_cnt = '0;
							tick = 1'b1;
						end else begin
							c_d.per_cnt = c_q.per_cnt + 16'd1;
						end
					end else begin
						c_d.base_cnt = c_q.base_cnt + 16'd1;
					end
				end
				if (tick) begin
					c_d.rate_q = RATE_SAMPLE;
					c_d.rate_ext_q = RATE_EXT_SAMPLE & ext_mask(dec_set);
					c_d.temp_q = TEMP_SAMPLE;
					c_d.dr_cnt = 3'(RSSPI_DR_PULSE_CYC);
				end
			end
			ST_SAVE: begin
				if (c_q.save_idx == 5'(NBYTES - 1)) begin
					c_d.st = ST_RUN;
					c_d.flash_cnt = c_q.flash_cnt + 16'd1;
				end else begin
					c_d.save_idx = c_q.save_idx + 5'd1;
				end
			end
			default: begin
				c_d.st = ST_INIT;
			end
		endcase
		if (rx_new) begin
			c_d.tog_seen = c_q.tog_sync[2];
			// answer loads for the next frame; overlapped request
			c_d.tx_en = ~rx_word[RSSPI_RW_BIT];
			if (!rx_word[RSSPI_RW_BIT]) begin
				// address in upper byte, low byte even
				case ({rx_addr[6:1], 1'b0})
					RSSPI_ADDR_FLASH_CNT: c_d.tx_word = c_q.flash_cnt;
					RSSPI_ADDR_TEMP: c_d.tx_word = c_q.temp_q;
					RSSPI_ADDR_RATE_LOW: c_d.tx_word = c_q.rate_ext_q;
					RSSPI_ADDR_RATE_HIGH: c_d.tx_word = c_q.rate_q;
					default: c_d.tx_word = is_cfg(rx_addr) ? cfg_word(rx_addr) : 16'h0000;
				endcase
			end else if (is_cfg(rx_addr)) begin
				wr_cfg = (c_q.st != ST_SAVE);
			end else if (rx_addr == RSSPI_ADDR_GLOBAL_COMMAND && rx_word[RSSPI_BACKUP_BIT]
				&& c_q.st == ST_RUN) begin
				c_d.st = ST_SAVE;
				c_d.save_idx = '0;
			end
			// read-only and unmapped addresses fall through
		end
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			c_q <= '{st: ST_INIT, default: '0};
		end else if (CE) begin
			c_q <= c_d;
		end
	end

	// working bytes: reload from flash in init, host writes, save to flash
	// plain always: flash model also preset at configuration
	always @(posedge MCLK) begin
		if (CE) begin
			if (c_q.st == ST_INIT) begin
				for (int k = 0; k < NBYTES; k++) begin
					work_q[k] <= flash_q[k];
				end
			end else if (wr_cfg) begin
				work_q[cfg_idx(rx_addr)] <= rx_word[7:0];
			end
			if (c_q.st == ST_SAVE) begin
				flash_q[c_q.save_idx] <= work_q[c_q.save_idx];
				if (c_q.save_idx == 5'(NBYTES - 1)) begin
					flash_cnt_nv <= c_q.flash_cnt + 16'd1;
				end
			end
		end
	end

	// flash model preset to documented defaults at configuration
	initial begin
		flash_cnt_nv = 16'h0000;
		for (int k = 0; k < NBYTES; k++) begin
			flash_q[k] = 8'h00;
		end
		flash_q[cfg_idx(RSSPI_ADDR_MSC)] = RSSPI_MSC_RST[7:0];
		flash_q[cfg_idx(RSSPI_ADDR_SAMPLE_PERIOD_SETTING)] = RSSPI_SAMPLE_PERIOD_SETTING_RST[7:0];
	end

	assign MISO = miso_w;
	assign MISO_OE = miso_oe_w;
	assign SAMPLE_DONE_PIN = c_q.dr_pin;
	assign FLASH_WRITE_COUNT = c_q.flash_cnt;
	assign EXT_CLOCK_MODE = c_q.ext_mode;
	assign DECIMATION_SETTING = dec_set;
endmodule
`default_nettype wire

// ### testbench/rsspi_top_asserts.sv
// checker: port behaviour of the rate sensor serial port
`timescale 1ns/1ns
`default_nettype none
module rsspi_top_asserts #(
	parameter int INIT_CYC = 10
) (
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic CS_N,
	input wire logic MISO_OE,
	input wire logic SAMPLE_DONE_PIN,
	input wire logic [15:0] FLASH_WRITE_COUNT,
	input wire logic EXT_CLOCK_MODE,
	input wire logic [4:0] DECIMATION_SETTING
);
	logic [31:0] up_q;
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			up_q <= '0;
		end else if (up_q < INIT_CYC) begin
			up_q <= up_q + 1;
		end
	end
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RSTN);
	AST_OE_ON: assert property (!CS_N [*2] |-> MISO_OE)
		else $error("output off in frame");
	AST_OE_OFF: assert property (CS_N [*2] |-> !MISO_OE)
		else $error("output on while idle");
	AST_DR_WIDTH: assert property ($rose(SAMPLE_DONE_PIN) |-> SAMPLE_DONE_PIN [*4] ##1 !SAMPLE_DONE_PIN)
		else $error("ready pulse width");
	AST_DR_GAP: assert property ($fell(SAMPLE_DONE_PIN) |-> !SAMPLE_DONE_PIN [*8])
		else $error("ready pulses too close");
	AST_INIT: assert property (SAMPLE_DONE_PIN |-> up_q >= INIT_CYC)
		else $error("sample before init");
	AST_CNT_STEP: assert property ($changed(FLASH_WRITE_COUNT) |-> FLASH_WRITE_COUNT == $past(FLASH_WRITE_COUNT) + 16'h0001)
		else $error("backup count jump");
	AST_CNT_FRAME: assert property (!CS_N |-> $stable(FLASH_WRITE_COUNT))
		else $error("backup count moved in frame");
	AST_CFG_FRAME: assert property (!CS_N && $past(!CS_N, 8) |-> $stable({EXT_CLOCK_MODE, DECIMATION_SETTING}))
		else $error("setting moved in frame");
endmodule
bind rsspi_top rsspi_top_asserts #(.INIT_CYC(INIT_CYC)) rsspi_top_asserts_i (.MCLK(MCLK), .RSTN(RSTN), .CS_N(CS_N),
	.MISO_OE(MISO_OE), .SAMPLE_DONE_PIN(SAMPLE_DONE_PIN), .FLASH_WRITE_COUNT(FLASH_WRITE_COUNT),
	.EXT_CLOCK_MODE(EXT_CLOCK_MODE), .DECIMATION_SETTING(DECIMATION_SETTING));
`default_nettype wire

// ### testbench/rsspi_host_model.sv
// model: host serial master of the rate sensor port
`timescale 1ns/1ns
`default_nettype none
module rsspi_host_model (
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso,
	input wire logic miso_oe
);
	logic line;
	// released line never shows the last bit
	assign line = miso_oe ? miso : ~miso;
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		mosi = 1'b1;
	end
	// one frame, msb first, then the idle gap
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		cs_n <= 1'b0;
		#60;
		for (int i = 15; i >= 0; i--) begin
			sclk <= 1'b0;
			mosi <= w[i];
			#15;
			sclk <= 1'b1;
			r[i] = line;
			#15;
		end
		cs_n <= 1'b1;
		mosi <= ~mosi;
		// long stall between frames keeps word rate low
		#15000;
	endtask
endmodule
`default_nettype wire

// ### testbench/test_rate_sensor_spi_register_port.sv
// testbench: rate sensor serial register port
`timescale 1ns/1ns
`default_nettype none
module test_rate_sensor_spi_register_port;
	typedef struct packed {
		logic [15:0] w;
		logic [15:0] a;
	} rsspi_row_type;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic aux = 1'b0;
	logic sclk, cs_n, mosi, miso, miso_oe, done, ext_mode;
	logic [15:0] rate = 16'h6021;
	logic [15:0] rext = 16'hFFFF;
	logic [15:0] temp = 16'hF165;
	logic [15:0] fcnt, r;
	logic [4:0] dec;
	int fail_count = 0;
	int checked = 0;
	rsspi_row_type rows [10] = '{
		'{16'h0600, 16'h6021},
		'{16'h0200, 16'hF165},
		'{16'h0400, 16'h0000},
		'{16'h1F00, 16'h000F},
		'{16'h9E00, 16'h0000},
		'{16'h9F00, 16'h0000},
		'{16'hA203, 16'h0000},
		'{16'h0000, 16'h0000},
		'{16'h0600, 16'h6021},
		'{16'h0000, 16'h0000}
	};
	always #25 mclk = ~mclk;
	rsspi_top #(.INIT_CYC(10)) rsspi_top_i (.MCLK(mclk), .RSTN(rstn), .CE(1'b1), .SCLK(sclk), .CS_N(cs_n),
		.MOSI(mosi), .MISO(miso), .MISO_OE(miso_oe), .SAMPLE_DONE_PIN(done), .AUX_IO_OR_EXT_CLOCK_PIN(aux),
		.RATE_SAMPLE(rate), .RATE_EXT_SAMPLE(rext), .TEMP_SAMPLE(temp), .FLASH_WRITE_COUNT(fcnt),
		.EXT_CLOCK_MODE(ext_mode), .DECIMATION_SETTING(dec));
	rsspi_host_model rsspi_host_model_i (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic port_chk(input logic [15:0] c, input logic e, input logic [4:0] d);
		@(negedge mclk);
		chk(fcnt, c);
		chk({15'h0000, ext_mode}, {15'h0000, e});
		chk({11'h000, dec}, {11'h000, d});
	endtask
	task automatic stop_test();
		$display("checked %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic reset_dut();
		@(posedge mclk);
		rstn <= 1'b0;
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
	endtask
	task automatic wait_done();
		int n;
		n = 0;
		while (done !== 1'b1 && n < 30000) begin
			@(posedge mclk);
			n++;
		end
		if (n == 30000) begin
			fail_count++;
			$display("unexpected at %0t: no sample pulse", $time);
			stop_test();
		end
	endtask
	initial begin
		reset_dut();
		wait_done();
		foreach (rows[i]) begin
			rsspi_host_model_i.xfer(rows[i].w, r);
			if (i > 0) begin
				chk(r, rows[i - 1].a);
			end
		end
		port_chk(16'h0000, 1'b1, 5'h03);
		$display("row reads done");
		@(posedge mclk);
		aux <= 1'b1;
		wait_done();
		repeat (10) @(posedge mclk);
		aux <= 1'b0;
		rsspi_host_model_i.xfer(16'h0400, r);
		rsspi_host_model_i.xfer(16'h8612, r);
		chk(r, 16'hE000);
		rsspi_host_model_i.xfer(16'h0600, r);
		chk(r, 16'h0000);
		rsspi_host_model_i.xfer(16'h0000, r);
		chk(r, 16'h6021);
		$display("external sample done");
		rsspi_host_model_i.xfer(16'hA808, r);
		rsspi_host_model_i.xfer(16'hA205, r);
		port_chk(16'h0001, 1'b1, 5'h05);
		chk({15'h0000, miso_oe}, 16'h0000);
		$display("backup done");
		reset_dut();
		repeat (30) @(posedge mclk);
		port_chk(16'h0001, 1'b1, 5'h03);
		$display("restore done");
		stop_test();
	end
endmodule
`default_nettype wire
